/* src/stxe_core.sv */
// execution stage for skips, table reads and xor instructions
`timescale 1ns/1ps
module stxe_core
  import stxe_pkg::*;
(
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_valid,
  input  wire stxe_pkg::stxe_op_e        i_op,
  input  wire logic [7:0]                i_mem,
  input  wire logic [7:0]                i_literal,
  input  wire logic [2:0]                i_bit_idx,
  input  wire logic [7:0]                i_table_pointer,
  input  wire logic [6:0]                i_pc_page,
  input  wire logic [15:0]               i_rom_word,
  output logic                           o_busy,
  output logic                           o_done,
  output logic                           o_discard_prefetch,
  output logic [stxe_pkg::STXE_ROM_AW-1:0] o_rom_addr,
  output logic                           o_rom_rd,
  output logic                           o_mem_we,
  output logic [7:0]                     o_mem_wdata,
  output logic [7:0]                     o_acc,
  output logic [7:0]                     o_table_high_byte,
  output logic                           o_zero_flag
);
  import stxe_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  // two flip-flops release the asynchronous reset
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // a request counts only outside the dummy cycle
  function automatic logic req_taken(input logic valid, input logic busy);
    return valid && !busy;
  endfunction : req_taken

  // both table reads share the rom strobe and the split of the word
  function automatic logic is_table_op(input stxe_op_e op);
    return (op == STXE_OP_TABLE_READ_CURRENT) || (op == STXE_OP_TABLE_READ_LAST);
  endfunction : is_table_op

  // the pointer picks the word, the op picks the program page or the last page
  function automatic logic [STXE_ROM_AW-1:0] table_addr(
    input stxe_op_e   op,
    input logic [6:0] pc_page,
    input logic [7:0] pointer
  );
    logic [6:0] page;
    page = (op == STXE_OP_TABLE_READ_LAST) ? STXE_LAST_PAGE : pc_page;
    return {page, pointer};
  endfunction : table_addr

  // ----------------------------------------
  // operation decode
  // ----------------------------------------
  logic       alu_skip;
  logic [7:0] alu_result;
  logic       alu_wr_acc;
  logic       alu_wr_mem;
  logic       alu_wr_tbh;
  logic       alu_wr_zero;
  stxe_op_e   op_eff;

  // ignore new requests while the dummy cycle runs
  logic take;
  assign take   = req_taken(i_valid, o_busy);
  assign op_eff = take ? i_op : STXE_OP_NONE;

  stxe_alu u_alu (
    .i_op       (op_eff),
    .i_mem      (i_mem),
    .i_acc      (o_acc),
    .i_literal  (i_literal),
    .i_bit_idx  (i_bit_idx),
    .i_rom_word (i_rom_word),
    .o_skip     (alu_skip),
    .o_result   (alu_result),
    .o_wr_acc   (alu_wr_acc),
    .o_wr_mem   (alu_wr_mem),
    .o_wr_tbh   (alu_wr_tbh),
    .o_wr_zero  (alu_wr_zero)
  );

  // ----------------------------------------
  // table address
  // ----------------------------------------
  logic [STXE_ROM_AW-1:0] rom_addr_d;
  logic                   rom_rd_d;
  logic [7:0]             tbh_d;

  // address and high byte of a table read; both hold between reads
  always_comb begin
    rom_rd_d   = 1'b0;
    rom_addr_d = o_rom_addr;
    tbh_d      = o_table_high_byte;
    if (take && is_table_op(i_op)) begin
      rom_addr_d = table_addr(i_op, i_pc_page, i_table_pointer);
      rom_rd_d   = 1'b1;
    end
    // high byte lands in the same cycle as the low byte goes to memory
    if (alu_wr_tbh) begin
      tbh_d = i_rom_word[15:8];
    end
  end

  // table read registers: address, strobe and high byte
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_rom_addr        <= '0;
      o_rom_rd          <= 1'b0;
      o_table_high_byte <= STXE_TBH_RST;
    end else begin
      o_rom_addr        <= rom_addr_d;
      o_rom_rd          <= rom_rd_d;
      o_table_high_byte <= tbh_d;
    end
  end

  // ----------------------------------------
  // instruction timing
  // ----------------------------------------
  // a taken skip costs one extra cycle; the word that was fetched behind
  // the skip is thrown away and the fetch side refills during the dummy
  typedef enum logic [0:0] {STXE_ST_RUN, STXE_ST_DUMMY} stxe_state_e;
  stxe_state_e state_q;
  stxe_state_e state_d;
  logic        busy_d;
  logic        done_d;
  logic        discard_d;

  // next state: a taken skip enters the dummy cycle for exactly one cycle
  always_comb begin
    state_d   = state_q;
    busy_d    = 1'b0;
    done_d    = 1'b0;
    discard_d = 1'b0;
    case (state_q)
      STXE_ST_RUN: begin
        if (take) begin
          if (alu_skip) begin
            state_d   = STXE_ST_DUMMY;
            busy_d    = 1'b1;
            discard_d = 1'b1;
          end else begin
            done_d = 1'b1;
          end
        end
      end
      STXE_ST_DUMMY: begin
        state_d = STXE_ST_RUN;
        done_d  = 1'b1;
      end
      default: begin
        state_d = STXE_ST_RUN;
      end
    endcase
  end

  // timing registers; busy is registered so requests see it settled
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q            <= STXE_ST_RUN;
      o_busy             <= 1'b0;
      o_done             <= 1'b0;
      o_discard_prefetch <= 1'b0;
    end else begin
      state_q            <= state_d;
      o_busy             <= busy_d;
      o_done             <= done_d;
      o_discard_prefetch <= discard_d;
    end
  end

  // ----------------------------------------
  // accumulator, zero flag and memory write
  // ----------------------------------------
  logic       mem_we_d;
  logic [7:0] mem_wdata_d;
  logic [7:0] acc_d;
  logic       zero_d;

  // skip tests raise no write strobe, so a tested byte stays as it was
  always_comb begin
    mem_we_d    = alu_wr_mem;
    mem_wdata_d = alu_result;
    acc_d       = alu_wr_acc ? alu_result : o_acc;
    zero_d      = alu_wr_zero ? (alu_result == 8'h00) : o_zero_flag;
  end

  // data registers; write data toggles freely, only the strobe qualifies it
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_mem_we    <= 1'b0;
      o_mem_wdata <= 8'h00;
      o_acc       <= STXE_ACC_RST;
      o_zero_flag <= 1'b0;
    end else begin
      o_mem_we    <= mem_we_d;
      o_mem_wdata <= mem_wdata_d;
      o_acc       <= acc_d;
      o_zero_flag <= zero_d;
    end
  end
endmodule : stxe_core

/* src/stxe_pkg.sv */
// package for the skip, table read and xor execution block
package stxe_pkg;
  // ----------------------------------------
  // operation codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    STXE_OP_NONE,
    STXE_OP_SKIP_IF_ZERO,
    STXE_OP_COPY_SKIP_IF_ZERO,
    STXE_OP_SKIP_IF_BIT_ZERO,
    STXE_OP_TABLE_READ_CURRENT,
    STXE_OP_TABLE_READ_LAST,
    STXE_OP_XOR_TO_ACC,
    STXE_OP_XOR_TO_MEMORY,
    STXE_OP_XOR_IMMEDIATE
  } stxe_op_e;

  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int          STXE_DATA_W       = 8;
  localparam int          STXE_ROM_AW       = 15;
  localparam int          STXE_PAGE_W       = STXE_ROM_AW - STXE_DATA_W;
  localparam logic [7:0]  STXE_ACC_RST      = 8'h00;
  localparam logic [7:0]  STXE_TBH_RST      = 8'h00;
  localparam logic [6:0]  STXE_LAST_PAGE    = 7'h7f;
  localparam int          STXE_SKIP_CYCLES  = 2;
  localparam int          STXE_PLAIN_CYCLES = 1;
endpackage : stxe_pkg

/* src/stxe_alu.sv */
// combinational result and skip decision for each operation
`timescale 1ns/1ps
module stxe_alu
  import stxe_pkg::*;
(
  input  wire stxe_pkg::stxe_op_e i_op,
  input  wire logic [7:0]         i_mem,
  input  wire logic [7:0]         i_acc,
  input  wire logic [7:0]         i_literal,
  input  wire logic [2:0]         i_bit_idx,
  input  wire logic [15:0]        i_rom_word,
  output logic                    o_skip,
  output logic [7:0]              o_result,
  output logic                    o_wr_acc,
  output logic                    o_wr_mem,
  output logic                    o_wr_tbh,
  output logic                    o_wr_zero
);
  import stxe_pkg::*;

  // decode one operation into its effects
  always_comb begin
    o_skip    = 1'b0;
    o_result  = 8'h00;
    o_wr_acc  = 1'b0;
    o_wr_mem  = 1'b0;
    o_wr_tbh  = 1'b0;
    o_wr_zero = 1'b0;
    case (i_op)
      STXE_OP_SKIP_IF_ZERO: begin
        o_skip = (i_mem == 8'h00);
      end
      STXE_OP_COPY_SKIP_IF_ZERO: begin
        o_result = i_mem;
        o_wr_acc = 1'b1;
        o_skip   = (i_mem == 8'h00);
      end
      STXE_OP_SKIP_IF_BIT_ZERO: begin
        o_skip = ~i_mem[i_bit_idx];
      end
      STXE_OP_TABLE_READ_CURRENT, STXE_OP_TABLE_READ_LAST: begin
        o_result = i_rom_word[7:0];
        o_wr_mem = 1'b1;
        o_wr_tbh = 1'b1;
      end
      STXE_OP_XOR_TO_ACC: begin
        o_result  = i_acc ^ i_mem;
        o_wr_acc  = 1'b1;
        o_wr_zero = 1'b1;
      end
      STXE_OP_XOR_TO_MEMORY: begin
        o_result  = i_acc ^ i_mem;
        o_wr_mem  = 1'b1;
        o_wr_zero = 1'b1;
      end
      STXE_OP_XOR_IMMEDIATE: begin
        o_result  = i_acc ^ i_literal;
        o_wr_acc  = 1'b1;
        o_wr_zero = 1'b1;
      end
      default: begin
        o_skip = 1'b0;
      end
    endcase
  end
endmodule : stxe_alu

/* sim/stxe_core_props.sv */
// assertions on the ports of stxe_core
`timescale 1ns/1ps
module stxe_core_props
  import stxe_pkg::*;
(
  input wire logic                             i_sys_clk,
  input wire logic                             i_arst_n,
  input wire logic                             i_valid,
  input wire stxe_pkg::stxe_op_e               i_op,
  input wire logic [7:0]                       i_mem,
  input wire logic [7:0]                       i_literal,
  input wire logic [2:0]                       i_bit_idx,
  input wire logic [7:0]                       i_table_pointer,
  input wire logic [6:0]                       i_pc_page,
  input wire logic [15:0]                      i_rom_word,
  input wire logic                             o_busy,
  input wire logic                             o_done,
  input wire logic                             o_discard_prefetch,
  input wire logic [stxe_pkg::STXE_ROM_AW-1:0] o_rom_addr,
  input wire logic                             o_rom_rd,
  input wire logic                             o_mem_we,
  input wire logic [7:0]                       o_mem_wdata,
  input wire logic [7:0]                       o_acc,
  input wire logic [7:0]                       o_table_high_byte,
  input wire logic                             o_zero_flag
);
  import stxe_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // accepted request and selected test bit
  logic take, bit_sel;
  assign take = i_valid && !o_busy;
  assign bit_sel = i_mem[i_bit_idx];
  sequence s_skip; o_discard_prefetch && o_busy && !o_mem_we ##1 o_done && !o_busy; endsequence
  sequence s_plain; o_done && !o_discard_prefetch && !o_busy && !o_mem_we; endsequence
  chk_zero_skip: assert property (take && i_op == STXE_OP_SKIP_IF_ZERO && i_mem == 8'h00 |=> s_skip)
    else $error("zero byte did not skip");
  chk_nonzero_run: assert property (take && i_op == STXE_OP_SKIP_IF_ZERO && i_mem != 8'h00 |=> s_plain)
    else $error("nonzero byte skipped");
  chk_copy_skip: assert property (take && i_op == STXE_OP_COPY_SKIP_IF_ZERO |=>
    o_acc == $past(i_mem) && o_discard_prefetch == ($past(i_mem) == 8'h00))
    else $error("copy skip wrong");
  chk_bit_skip: assert property (take && i_op == STXE_OP_SKIP_IF_BIT_ZERO |=>
    o_discard_prefetch == !$past(bit_sel))
    else $error("bit skip wrong");
  chk_table_current: assert property (take && i_op == STXE_OP_TABLE_READ_CURRENT |=>
    o_mem_we && o_done && o_rom_rd && o_rom_addr == {$past(i_pc_page), $past(i_table_pointer)} &&
    {o_table_high_byte, o_mem_wdata} == $past(i_rom_word))
    else $error("current page read wrong");
  chk_table_last: assert property (take && i_op == STXE_OP_TABLE_READ_LAST |=>
    o_mem_we && o_done && o_rom_rd && o_rom_addr == {STXE_LAST_PAGE, $past(i_table_pointer)} &&
    {o_table_high_byte, o_mem_wdata} == $past(i_rom_word))
    else $error("last page read wrong");
  chk_xor_acc: assert property (take && i_op == STXE_OP_XOR_TO_ACC |=> !o_mem_we &&
    o_acc == ($past(o_acc) ^ $past(i_mem)) && o_zero_flag == (o_acc == 8'h00))
    else $error("xor to accumulator wrong");
  chk_xor_mem: assert property (take && i_op == STXE_OP_XOR_TO_MEMORY |=> o_mem_we && $stable(o_acc) &&
    o_mem_wdata == ($past(o_acc) ^ $past(i_mem)) && o_zero_flag == (o_mem_wdata == 8'h00))
    else $error("xor to memory wrong");
  chk_xor_imm: assert property (take && i_op == STXE_OP_XOR_IMMEDIATE |=> !o_mem_we &&
    o_acc == ($past(o_acc) ^ $past(i_literal)) && o_zero_flag == (o_acc == 8'h00))
    else $error("xor immediate wrong");
  chk_dummy_ignored: assert property (o_busy |=> $stable(o_acc) && $stable(o_zero_flag) && !o_mem_we && !o_rom_rd)
    else $error("request taken in dummy cycle");
endmodule : stxe_core_props

bind stxe_core stxe_core_props i_stxe_core_props (
  .i_sys_clk          (i_sys_clk),
  .i_arst_n           (i_arst_n),
  .i_valid            (i_valid),
  .i_op               (i_op),
  .i_mem              (i_mem),
  .i_literal          (i_literal),
  .i_bit_idx          (i_bit_idx),
  .i_table_pointer    (i_table_pointer),
  .i_pc_page          (i_pc_page),
  .i_rom_word         (i_rom_word),
  .o_busy             (o_busy),
  .o_done             (o_done),
  .o_discard_prefetch (o_discard_prefetch),
  .o_rom_addr         (o_rom_addr),
  .o_rom_rd           (o_rom_rd),
  .o_mem_we           (o_mem_we),
  .o_mem_wdata        (o_mem_wdata),
  .o_acc              (o_acc),
  .o_table_high_byte  (o_table_high_byte),
  .o_zero_flag        (o_zero_flag)
);

/* sim/skip_table_xor_exec_test.sv */
// self-checking bench for the skip, table read and xor block
`timescale 1ns/1ps
module skip_table_xor_exec_test;
  import stxe_pkg::*;
  logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_valid = 1'b0;
  stxe_op_e i_op = STXE_OP_NONE;
  logic [7:0] i_mem = 8'h00, i_literal = 8'h00, i_table_pointer = 8'h00;
  logic [2:0] i_bit_idx = 3'h0;
  logic [6:0] i_pc_page = 7'h00;
  logic [15:0] i_rom_word = 16'h0000;
  logic o_busy, o_done, o_discard_prefetch, o_rom_rd, o_mem_we, o_zero_flag;
  logic [14:0] o_rom_addr;
  logic [7:0] o_mem_wdata, o_acc, o_table_high_byte;
  int num_errors = 0, tests_run = 0, cycles = 0;
  int acc = STXE_ACC_RST, tbh = STXE_TBH_RST, zf = 0, addr = 0, wd, we, rd, sk, res;
  logic [47:0] exp_q[$];
  // device under test
  stxe_core i_stxe_core (
    .i_sys_clk          (i_sys_clk),
    .i_arst_n           (i_arst_n),
    .i_valid            (i_valid),
    .i_op               (i_op),
    .i_mem              (i_mem),
    .i_literal          (i_literal),
    .i_bit_idx          (i_bit_idx),
    .i_table_pointer    (i_table_pointer),
    .i_pc_page          (i_pc_page),
    .i_rom_word         (i_rom_word),
    .o_busy             (o_busy),
    .o_done             (o_done),
    .o_discard_prefetch (o_discard_prefetch),
    .o_rom_addr         (o_rom_addr),
    .o_rom_rd           (o_rom_rd),
    .o_mem_we           (o_mem_we),
    .o_mem_wdata        (o_mem_wdata),
    .o_acc              (o_acc),
    .o_table_high_byte  (o_table_high_byte),
    .o_zero_flag        (o_zero_flag)
  );
  // 200 MHz clock and hang guard
  always #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic cmp(logic [47:0] got, logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // one random instruction against the reference model
  task automatic step(stxe_op_e op);
    i_op = op;
    i_mem = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
    i_literal = 8'($urandom);
    i_bit_idx = 3'($urandom);
    i_table_pointer = 8'($urandom);
    i_pc_page = 7'($urandom);
    i_rom_word = 16'($urandom);
    i_valid = 1'b1;
    we = 0;
    rd = 0;
    sk = 0;
    wd = 0;
    case (op)
      STXE_OP_SKIP_IF_ZERO: sk = (i_mem == 0);
      STXE_OP_COPY_SKIP_IF_ZERO: begin
        acc = i_mem;
        sk  = (i_mem == 0);
      end
      STXE_OP_SKIP_IF_BIT_ZERO: sk = !i_mem[i_bit_idx];
      STXE_OP_TABLE_READ_CURRENT, STXE_OP_TABLE_READ_LAST: begin
        rd   = 1;
        we   = 1;
        wd   = i_rom_word[7:0];
        tbh  = i_rom_word[15:8];
        addr = {(op == STXE_OP_TABLE_READ_LAST) ? STXE_LAST_PAGE : i_pc_page, i_table_pointer};
      end
      default: begin
        res = acc ^ ((op == STXE_OP_XOR_IMMEDIATE) ? i_literal : i_mem);
        zf  = (res == 0);
        if (op == STXE_OP_XOR_TO_MEMORY) begin
          we = 1;
          wd = res;
        end else begin
          acc = res;
        end
      end
    endcase
    exp_q.push_back(48'({1'(!sk), 1'(sk), 1'(sk), 1'(rd), 1'(we), 8'(wd), 8'(acc), 8'(tbh), 1'(zf), 15'(addr)}));
    @(negedge i_sys_clk);
    // an xor offered during the dummy cycle must be ignored
    if (sk != 0) begin
      i_op  = STXE_OP_XOR_TO_ACC;
      i_mem = 8'h5a;
    end
    cmp({o_done, o_discard_prefetch, o_busy, o_rom_rd, o_mem_we, we != 0 ? o_mem_wdata : 8'h00,
      o_acc, o_table_high_byte, o_zero_flag, o_rom_addr}, exp_q.pop_front());
    if (sk != 0) begin
      @(negedge i_sys_clk);
      i_valid = 1'b0;
      cmp({o_done, o_busy, o_acc}, {2'b10, 8'(acc)});
      @(negedge i_sys_clk);
    end
  endtask : step
  initial begin
    void'($urandom(32'hd35f));
    repeat (16) @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    cmp({o_acc, o_table_high_byte, o_zero_flag, o_busy, o_done}, {STXE_ACC_RST, STXE_TBH_RST, 3'b000});
    $display("reset value test done");
    for (int i = 0; i < 300; i++) step(stxe_op_e'(1 + $urandom % 8));
    i_valid = 1'b0;
    $display("random instruction test done");
    conclude();
  end
endmodule : skip_table_xor_exec_test
